//--- common/video_lock_defs.svh
/*
  Shared constants of the video input port and of the stream source:
  register offsets, field positions, reset values, code bytes, timing.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef VIDEO_LOCK_DEFS_SVH
`define VIDEO_LOCK_DEFS_SVH
// =====================================================================
// register offsets (byte addresses, one word each)
`define MODE_OFS 8'h00
`define POL_OFS 8'h04
`define BACK_OFS 8'h08
`define HPAR_OFS 8'h0C
`define VPAR_OFS 8'h10
`define RES_OFS 8'h14
`define STAT_OFS 8'h18
// =====================================================================
// display mode register fields
`define MODE_EN 0
`define MODE_EMB 1
`define MODE_DEQ 2
`define MODE_FMT 4:3
`define MODE_LOCK 15:8
`define MODE_RST 32'h0000_0100
// polarity register bits: set means active low / falling edge
`define POL_HS 0
`define POL_VS 1
`define POL_DE 2
`define POL_CLK 3
`define POL_RST 4'h0
// sync parameter and resolution fields
`define PAR_PW 7:0
`define PAR_BP 15:8
`define PAR_FP 23:16
`define RES_X 10:0
`define RES_Y 26:16
// status register bits
`define ST_PCLK 0
`define ST_HS 1
`define ST_VS 2
`define ST_DE 3
`define ST_BLANK 4
`define ST_LOCK 5
`define ST_FERR 6
// =====================================================================
// colour formats
`define FMT_RGB565 2'h0
`define FMT_RGB666 2'h1
`define FMT_MONO8 2'h2
// embedded timing codes
`define CODE_FF 8'hFF
`define CODE_00 8'h00
`define XY_BASE 8'h80
`define XY_V 5
`define XY_H 4
`define BLANK_BYTE 8'h10
`define CODE_LEN 11'h004
// =====================================================================
// source pixel clock divider
`define CLK_PERIOD_NS 8
`define PCLK_PERIOD_NS 125
`define PCLK_HALF_CYC ((`PCLK_PERIOD_NS / `CLK_PERIOD_NS) / 2)
`endif

//--- common/video_lock_pkg.sv
/*
  Types of the video input port: coordinates, pixels, lock states,
  and the pin to colour conversion.
  Assumes video_lock_defs.svh on the include path.
*/
`include "video_lock_defs.svh"
package video_lock_pkg;
  typedef logic [10:0] coord_type;
  typedef logic [23:0] rgb_type;
  typedef logic [17:0] pins_type;
  typedef enum logic [2:0] {
    LK_IDLE = 3'b001,
    LK_SEEK = 3'b010,
    LK_LOCKED = 3'b100
  } lock_state_type;

  // expand the data pins to 8 bits per colour
  function automatic rgb_type pins_to_rgb(input logic [1:0] fmt, input pins_type d);
    rgb_type c;
    c = 24'h000000;
    if (fmt == `FMT_RGB565) begin
      c = {d[15:11], d[15:13], d[10:5], d[10:9], d[4:0], d[4:2]};
    end else if (fmt == `FMT_RGB666) begin
      c = {d[17:12], d[17:16], d[11:6], d[11:10], d[5:0], d[5:4]};
    end else begin
      c = {d[7:0], d[7:0], d[7:0]};
    end
    return c;
  endfunction
endpackage

//--- common/video_link_if.sv
/*
  Parallel video link between a stream source and the video input port.
  Assumes the source drives every wire; the port only samples them.
*/
`timescale 1ns/1ps
interface video_link_if;
  logic pclk;
  logic hsync;
  logic vsync;
  logic de;
  logic [17:0] data;
  modport source (output pclk, output hsync, output vsync, output de, output data);
  modport port (input pclk, input hsync, input vsync, input de, input data);
endinterface

//--- core/video_sync_sampler.sv
/*
  Two-flop synchroniser for a group of link wires.
  Assumes the wires change slowly against clock_in, so group skew is harmless.
*/
`timescale 1ns/1ps
module video_sync_sampler #(
  parameter int WIDTH = 22
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  // =====================================================================
  // first stage feeds only the second stage
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // video_sync_sampler

//--- core/video_input_port.sv
/*
  Video input port: samples a parallel pixel stream with its timing, checks
  it against the programmed display timing, locks after enough clean frames
  and then hands the stream to the display controller in place of the
  background colour.
  Assumes a source that keeps the stream format below, a software port with
  read data one cycle after the read strobe, and a link far slower than clock_in.
  // Behaviour
  // - embedded mode rejects vertical change at EAV
  // - field bit of timing codes ignored
  // - source frame: active lines, then blanking lines
  // - active line: SAV, data, EAV, blanking
  // - blanking line: SAV, blank, EAV, blanking
  // - vertical flag changes only inside SAV
  // - lock after configured count of clean frames
  // - software sets qualify bit when data enable present
  // - colour format selects pixel encoding
  // - sync select zero uses dedicated timing pins
  // - polarity applied to timing before checking
  // - monitoring starts only when enable set
  // - software enables the port last
  // - background colour shown while unlocked
  // - locked video replaces background layer
  // - status shows detected timing signals
  // - blanking flag shows sync widths match
  // - any width or porch mismatch refuses lock
  // - data enable may be ignored entirely
  // - locked timing forwarded at source rate
*/
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module video_input_port
  import video_lock_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  video_link_if.port link,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [31:0] reg_rdata_out,
  output logic lock_out,
  output logic use_video_out,
  output logic [23:0] pixel_out,
  output logic pixel_valid_out,
  output logic disp_hsync_out,
  output logic disp_vsync_out,
  output logic disp_de_out,
  output logic disp_tick_out
);
  logic [31:0] mode_r;
  logic [3:0] pol_r;
  rgb_type back_r;
  logic [23:0] hpar_r;
  logic [23:0] vpar_r;
  logic [26:0] res_r;
  logic [21:0] s_bus;
  logic s_pclk, s_hs, s_vs, s_de, pclk_prev_r;
  pins_type s_data;
  logic en, emb, deq, tick;
  logic [7:0] b1_r, b2_r, b3_r;
  logic h_emb_r, v_emb_r, is_xy, emb_err;
  logic hs_now, vs_now, de_now, hs_prev_r, vs_prev_r, de_prev_r;
  logic hs_rise, hs_fall, vs_rise, vs_fall, de_rise, de_fall;
  coord_type hcnt_r, hw_r, vl_r, vw_r, pos, line_idx;
  coord_type h_blank, v_blank, exp_hw, exp_vw, htot, vtot, h_start, v_start;
  logic h_armed_r, f_armed_r, frame_err_r, err_now, good;
  logic h_ok_r, v_ok_r, act;
  logic [3:0] seen_r;
  logic [7:0] good_cnt_r, lock_need;
  lock_state_type state_r;

  // =====================================================================
  // link sampling: every link wire passes two flops first
  video_sync_sampler #(.WIDTH(22)) u_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .async_in({link.pclk, link.hsync, link.vsync, link.de, link.data}),
    .sync_out(s_bus)
  );
  assign {s_pclk, s_hs, s_vs, s_de, s_data} = s_bus;

  assign en = mode_r[`MODE_EN];
  assign emb = mode_r[`MODE_EMB];
  assign deq = mode_r[`MODE_DEQ] & ~emb;
  assign lock_need = (mode_r[`MODE_LOCK] == 8'h00) ? 8'h01 : mode_r[`MODE_LOCK];

  // pixel clock edge chosen by polarity; nothing runs while disabled
  assign tick = en & (pol_r[`POL_CLK] ? (pclk_prev_r & ~s_pclk) : (~pclk_prev_r & s_pclk));

  // =====================================================================
  // embedded code decode: FF 00 00 then the flag byte
  assign is_xy = emb & (b3_r == `CODE_FF) & (b2_r == `CODE_00) & (b1_r == `CODE_00);
  // vertical change together with H going high is the EAV case the port refuses
  assign emb_err = is_xy & s_data[`XY_H] & ~h_emb_r & (s_data[`XY_V] != v_emb_r);

  // timing levels after polarity, or from the flags (field bit unused)
  always_comb begin
    hs_now = s_hs ^ pol_r[`POL_HS];
    vs_now = s_vs ^ pol_r[`POL_VS];
    de_now = (s_de ^ pol_r[`POL_DE]) & deq;
    if (emb) begin
      hs_now = is_xy ? s_data[`XY_H] : h_emb_r;
      vs_now = is_xy ? s_data[`XY_V] : v_emb_r;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pclk_prev_r <= 1'b0;
      b1_r <= 8'h00;
      b2_r <= 8'h00;
      b3_r <= 8'h00;
      h_emb_r <= 1'b0;
      v_emb_r <= 1'b0;
      hs_prev_r <= 1'b0;
      vs_prev_r <= 1'b0;
      de_prev_r <= 1'b0;
    end else begin
      pclk_prev_r <= s_pclk;
      if (tick) begin
        b1_r <= s_data[7:0];
        b2_r <= b1_r;
        b3_r <= b2_r;
        h_emb_r <= hs_now;
        v_emb_r <= vs_now;
        hs_prev_r <= hs_now;
        vs_prev_r <= vs_now;
        de_prev_r <= de_now;
      end
    end
  end

  assign hs_rise = tick & hs_now & ~hs_prev_r;
  assign hs_fall = tick & ~hs_now & hs_prev_r;
  assign vs_rise = tick & vs_now & ~vs_prev_r;
  assign vs_fall = tick & ~vs_now & vs_prev_r;
  assign de_rise = tick & de_now & ~de_prev_r;
  assign de_fall = tick & ~de_now & de_prev_r;

  // =====================================================================
  // expected timing from the parameter registers
  assign h_blank = coord_type'(hpar_r[`PAR_PW]) + coord_type'(hpar_r[`PAR_BP]) + coord_type'(hpar_r[`PAR_FP]);
  assign v_blank = coord_type'(vpar_r[`PAR_PW]) + coord_type'(vpar_r[`PAR_BP]) + coord_type'(vpar_r[`PAR_FP]);
  assign exp_hw = emb ? (h_blank - `CODE_LEN) : coord_type'(hpar_r[`PAR_PW]);
  assign exp_vw = emb ? v_blank : coord_type'(vpar_r[`PAR_PW]);
  assign htot = h_blank + res_r[`RES_X];
  assign vtot = v_blank + res_r[`RES_Y];
  assign h_start = coord_type'(hpar_r[`PAR_PW]) + coord_type'(hpar_r[`PAR_BP]);
  assign v_start = coord_type'(vpar_r[`PAR_PW]) + coord_type'(vpar_r[`PAR_BP]);
  assign pos = hs_rise ? 11'h000 : hcnt_r;
  assign line_idx = vl_r - 11'h001;

  // every width, the line and frame totals and the data enable positions must match to the clock
  assign err_now = (hs_rise & h_armed_r & (hcnt_r != htot))
                 | (hs_fall & h_armed_r & (hw_r != exp_hw))
                 | (vs_fall & f_armed_r & (vw_r != exp_vw))
                 | (de_rise & h_armed_r & (pos != h_start))
                 | (de_fall & h_armed_r & (pos != h_start + res_r[`RES_X]))
                 | emb_err;
  assign good = f_armed_r & ~frame_err_r & ~err_now & (vl_r == vtot);

  // =====================================================================
  // line, width and frame counters
  always_ff @(posedge clock_in) begin
    if (rst_in | ~en) begin
      hcnt_r <= 11'h000;
      hw_r <= 11'h000;
      vl_r <= 11'h000;
      vw_r <= 11'h000;
      h_armed_r <= 1'b0;
      f_armed_r <= 1'b0;
      frame_err_r <= 1'b0;
    end else if (tick) begin
      hcnt_r <= hs_rise ? 11'h001 : hcnt_r + 11'h001;
      hw_r <= hs_rise ? 11'h001 : hw_r + 11'h001;
      if (hs_rise) begin
        h_armed_r <= 1'b1;
      end
      if (vs_rise) begin
        vl_r <= {10'h000, hs_rise};
        vw_r <= {10'h000, hs_rise};
        f_armed_r <= h_armed_r;
        frame_err_r <= 1'b0; // this tick's errors were charged to the closing frame
      end else begin
        vl_r <= vl_r + {10'h000, hs_rise};
        vw_r <= vw_r + {10'h000, hs_rise & vs_now};
        frame_err_r <= frame_err_r | err_now;
      end
    end
  end

  // =====================================================================
  // lock machine
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_r <= LK_IDLE;
      good_cnt_r <= 8'h00;
    end else begin
      case (state_r)
        LK_IDLE: begin
          good_cnt_r <= 8'h00;
          if (en) begin
            state_r <= LK_SEEK;
          end
        end
        LK_SEEK, LK_LOCKED: begin
          if (~en) begin
            state_r <= LK_IDLE;
          end else if (vs_rise & f_armed_r) begin
            if (good) begin
              good_cnt_r <= (good_cnt_r == 8'hFF) ? good_cnt_r : good_cnt_r + 8'h01;
              if (good_cnt_r + 8'h01 >= lock_need) begin
                state_r <= LK_LOCKED;
              end
            end else begin
              good_cnt_r <= 8'h00;
              state_r <= LK_SEEK;
            end
          end
        end
        default: begin
          state_r <= LK_IDLE;
        end
      endcase
    end
  end

  // =====================================================================
  // status: detected signals and blanking match, cleared while disabled
  always_ff @(posedge clock_in) begin
    if (rst_in | ~en) begin
      seen_r <= 4'h0;
      h_ok_r <= 1'b0;
      v_ok_r <= 1'b0;
    end else begin
      seen_r <= seen_r | {de_rise, vs_rise, hs_rise, tick};
      if (hs_fall & h_armed_r) begin
        h_ok_r <= (hw_r == exp_hw);
      end
      if (vs_fall & f_armed_r) begin
        v_ok_r <= (vw_r == exp_vw);
      end
    end
  end

  // =====================================================================
  // pixel window and hand-over to the display controller
  always_comb begin
    if (emb) begin
      act = ~hs_now & ~vs_now & ~is_xy;
    end else if (deq) begin
      act = de_now;
    end else begin
      act = (pos >= h_start) & (pos < h_start + res_r[`RES_X])
          & (line_idx >= v_start) & (line_idx < v_start + res_r[`RES_Y]);
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pixel_out <= 24'h000000;
      pixel_valid_out <= 1'b0;
      disp_hsync_out <= 1'b0;
      disp_vsync_out <= 1'b0;
      disp_de_out <= 1'b0;
      disp_tick_out <= 1'b0;
    end else begin
      disp_tick_out <= tick;
      pixel_valid_out <= tick & act;
      if (tick) begin
        disp_hsync_out <= hs_now;
        disp_vsync_out <= vs_now;
        disp_de_out <= act;
        if (state_r == LK_LOCKED) begin
          pixel_out <= pins_to_rgb(mode_r[`MODE_FMT], s_data);
        end else begin
          pixel_out <= back_r;
        end
      end
    end
  end
  assign lock_out = (state_r == LK_LOCKED);
  assign use_video_out = lock_out;

  // =====================================================================
  // software registers; unmapped writes ignored, unmapped reads zero
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      mode_r <= `MODE_RST;
      pol_r <= `POL_RST;
      back_r <= 24'h000000;
      hpar_r <= 24'h000000;
      vpar_r <= 24'h000000;
      res_r <= 27'h0000000;
    end else if (reg_write_in) begin
      if (reg_addr_in == `MODE_OFS) begin
        mode_r <= {16'h0000, reg_wdata_in[`MODE_LOCK], 3'h0, reg_wdata_in[4:0]};
      end else if (reg_addr_in == `POL_OFS) begin
        pol_r <= reg_wdata_in[3:0];
      end else if (reg_addr_in == `BACK_OFS) begin
        back_r <= reg_wdata_in[23:0];
      end else if (reg_addr_in == `HPAR_OFS) begin
        hpar_r <= reg_wdata_in[23:0];
      end else if (reg_addr_in == `VPAR_OFS) begin
        vpar_r <= reg_wdata_in[23:0];
      end else if (reg_addr_in == `RES_OFS) begin
        res_r <= {reg_wdata_in[`RES_Y], 5'h00, reg_wdata_in[`RES_X]};
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (reg_read_in) begin
      if (reg_addr_in == `MODE_OFS) begin
        reg_rdata_out <= mode_r;
      end else if (reg_addr_in == `POL_OFS) begin
        reg_rdata_out <= {28'h0000000, pol_r};
      end else if (reg_addr_in == `BACK_OFS) begin
        reg_rdata_out <= {8'h00, back_r};
      end else if (reg_addr_in == `HPAR_OFS) begin
        reg_rdata_out <= {8'h00, hpar_r};
      end else if (reg_addr_in == `VPAR_OFS) begin
        reg_rdata_out <= {8'h00, vpar_r};
      end else if (reg_addr_in == `RES_OFS) begin
        reg_rdata_out <= {5'h00, res_r};
      end else if (reg_addr_in == `STAT_OFS) begin
        reg_rdata_out <= {25'h0000000, frame_err_r, lock_out, h_ok_r & v_ok_r, seen_r};
      end else begin
        reg_rdata_out <= 32'h00000000;
      end
    end else begin
      reg_rdata_out <= 32'h00000000;
    end
  end
endmodule // video_input_port

//--- core/video_stream_source.sv
/*
  Stream source: makes the pixel clock by a divider and sends frames with
  dedicated sync pins or with embedded codes in the order the port accepts.
  Assumes timing inputs are held steady while enable_in is high.
*/
`timescale 1ns/1ps
module video_stream_source
  import video_lock_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  video_link_if.source link,
  input wire logic enable_in,
  input wire logic embedded_in,
  input wire logic de_enable_in,
  input wire logic [23:0] hpar_in,
  input wire logic [23:0] vpar_in,
  input wire logic [10:0] x_res_in,
  input wire logic [10:0] y_res_in,
  input wire logic [17:0] pixel_in,
  output logic pixel_take_out,
  output logic frame_start_out
);
  logic [7:0] div_r;
  logic pclk_r, step;
  coord_type hc_r, vc_r, htot, vtot, hs_end, h_act, vs_end, v_act;
  logic act, vblank, hs, vs, de;
  pins_type dat;

  assign hs_end = coord_type'(hpar_in[`PAR_PW]);
  assign h_act = hs_end + coord_type'(hpar_in[`PAR_BP]);
  assign htot = h_act + x_res_in + coord_type'(hpar_in[`PAR_FP]);
  assign vs_end = coord_type'(vpar_in[`PAR_PW]);
  assign v_act = vs_end + coord_type'(vpar_in[`PAR_BP]);
  assign vtot = v_act + y_res_in + coord_type'(vpar_in[`PAR_FP]);

  // =====================================================================
  // pixel clock divider; data change on its falling edge
  always_ff @(posedge clock_in) begin
    if (rst_in | ~enable_in) begin
      div_r <= 8'h00;
      pclk_r <= 1'b0;
    end else if (div_r == 8'(`PCLK_HALF_CYC - 1)) begin
      div_r <= 8'h00;
      pclk_r <= ~pclk_r;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end
  assign step = enable_in & pclk_r & (div_r == 8'(`PCLK_HALF_CYC - 1));

  // =====================================================================
  // line and frame position
  always_ff @(posedge clock_in) begin
    if (rst_in | ~enable_in) begin
      hc_r <= 11'h000;
      vc_r <= 11'h000;
    end else if (step) begin
      if (hc_r == htot - 11'h001) begin
        hc_r <= 11'h000;
        vc_r <= (vc_r == vtot - 11'h001) ? 11'h000 : vc_r + 11'h001;
      end else begin
        hc_r <= hc_r + 11'h001;
      end
    end
  end

  // pin values for the current position
  always_comb begin
    vblank = vc_r >= y_res_in; // active lines come first
    hs = 1'b0;
    vs = 1'b0;
    de = 1'b0;
    dat = 18'h00000;
    act = 1'b0;
    if (embedded_in) begin
      act = ~vblank & (hc_r >= `CODE_LEN) & (hc_r < x_res_in + `CODE_LEN);
      dat = {10'h000, `BLANK_BYTE};
      if (act) begin
        dat = {10'h000, pixel_in[7:0]};
      end else if ((hc_r == 11'h000) | (hc_r == x_res_in + `CODE_LEN)) begin
        dat = {10'h000, `CODE_FF};
      end else if ((hc_r == 11'h001) | (hc_r == 11'h002) | (hc_r == x_res_in + 11'h005)
                   | (hc_r == x_res_in + 11'h006)) begin
        dat = {10'h000, `CODE_00};
      end else if (hc_r == 11'h003) begin
        dat = {10'h000, `XY_BASE | {2'h0, vblank, 5'h00}}; // SAV carries the V change
      end else if (hc_r == x_res_in + 11'h007) begin
        dat = {10'h000, `XY_BASE | {2'h0, vblank, 5'h10}};
      end
    end else begin
      hs = hc_r < hs_end;
      vs = vc_r < vs_end;
      act = (hc_r >= h_act) & (hc_r < h_act + x_res_in) & (vc_r >= v_act) & (vc_r < v_act + y_res_in);
      de = act & de_enable_in;
      dat = act ? pixel_in : 18'h00000;
    end
  end

  // =====================================================================
  // registered link outputs
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      link.hsync <= 1'b0;
      link.vsync <= 1'b0;
      link.de <= 1'b0;
      link.data <= 18'h00000;
      pixel_take_out <= 1'b0;
      frame_start_out <= 1'b0;
    end else begin
      pixel_take_out <= step & act;
      frame_start_out <= step & (hc_r == 11'h000) & (vc_r == 11'h000);
      if (step) begin
        link.hsync <= hs;
        link.vsync <= vs;
        link.de <= de;
        link.data <= dat;
      end
    end
  end
  assign link.pclk = pclk_r;
endmodule // video_stream_source

//--- test/video_link_sva.sv
/* link wire checker: timing words, line order and sync widths
   assumes the bench test timing: 8x4, h 2/2/2, v 1/1/1, 14 clocks per tick */
`timescale 1ns/1ps
module video_link_sva (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic pclk,
  input wire logic hsync,
  input wire logic vsync,
  input wire logic de,
  input wire logic [17:0] data
);
  // ==========================================
  // helpers: last timing word, active line count
  logic last_h_r, last_v_r, emb_r, xy;
  logic [3:0] act_r;
  logic [7:0] prev_r;
  // pixel and blank bytes never carry bit 7, so a fresh one is a timing word
  assign xy = data[7:0] != prev_r && data[7] && data[7:0] != 8'hFF;
  // track words; pin widths only mean something without embedded codes
  always_ff @(posedge clock_in) begin
    prev_r <= data[7:0];
    if (rst_in) begin
      last_h_r <= 1'h1;
      last_v_r <= 1'h1;
      emb_r <= 1'h0;
      act_r <= 4'h0;
    end else begin
      if (data[7:0] == 8'hFF) emb_r <= 1'h1;
      if (xy) last_h_r <= data[4];
      if (xy) last_v_r <= data[5];
      if (xy && !data[4]) act_r <= data[5] ? 4'h0 : act_r + 4'h1;
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // ==========================================
  // assertions
  property p_pclk_low; $fell(pclk) |=> !pclk [*6]; endproperty
  property p_preamble; $changed(data[7:0]) && $past(data[7:0]) == 8'hFF |-> data[7:0] == 8'h00; endproperty
  property p_h_alt; xy |-> data[4] != last_h_r; endproperty
  property p_v_at_sav; xy && data[4] |-> data[5] == last_v_r; endproperty
  property p_act_lines; xy && !data[4] && data[5] && !last_v_r |-> act_r == 4'h4; endproperty
  property p_hs_width; $rose(hsync) && !emb_r |-> ##27 hsync ##1 !hsync; endproperty
  property p_de_width; $rose(de) && !emb_r |-> ##111 de ##1 !de; endproperty
  property p_vs_width; $rose(vsync) && !emb_r |-> ##195 vsync ##1 !vsync; endproperty
  a_pclk_low: assert property (p_pclk_low) else $error("pixel clock low phase too short");
  a_preamble: assert property (p_preamble) else $error("timing word preamble broken");
  a_h_alt: assert property (p_h_alt) else $error("start and end words not alternating");
  a_v_at_sav: assert property (p_v_at_sav) else $error("vertical flag changed at end word");
  a_act_lines: assert property (p_act_lines) else $error("active line count wrong");
  a_hs_width: assert property (p_hs_width) else $error("hsync width wrong");
  a_de_width: assert property (p_de_width) else $error("data enable width wrong");
  a_vs_width: assert property (p_vs_width) else $error("vsync width wrong");
  c_vblank: cover property (xy && data[5]);
  c_de: cover property ($rose(de));
  c_vs: cover property ($rose(vsync) && !emb_r);
endmodule // video_link_sva

//--- test/parallel_video_input_lock_tb.sv
/* bench: source and port joined by one link, software port driven by tasks
   assumes the defs header, package and interface compiled first */
`timescale 1ns/1ps
module parallel_video_input_lock_tb;
  import video_lock_pkg::*;
  logic clock_in = 1'h0, rst_in = 1'h1, wr = 1'h0, rd = 1'h0;
  logic src_en = 1'h0, emb = 1'h0, de_en = 1'h1, lock, use_video, pvalid, dde;
  logic [7:0] addr = 8'h00;
  logic [23:0] src_hpar = 24'h020202;
  logic [31:0] wdata = 32'h0, rdata;
  logic [23:0] pixel;
  int n_mismatch = 0, n_tests = 0;
  video_link_if link ();
  video_input_port video_input_port_inst (.clock_in(clock_in), .rst_in(rst_in), .link(link),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata),
    .lock_out(lock), .use_video_out(use_video), .pixel_out(pixel), .pixel_valid_out(pvalid),
    .disp_hsync_out(), .disp_vsync_out(), .disp_de_out(dde), .disp_tick_out());
  // panel 8x4 pixels, 1/1/1 lines; 2/2/2 clocks, widened to 2/3/3 for embedded codes
  // since start and end words need eight blanking clocks between lines
  video_stream_source video_stream_source_inst (.clock_in(clock_in), .rst_in(rst_in), .link(link),
    .enable_in(src_en), .embedded_in(emb), .de_enable_in(de_en), .hpar_in(src_hpar), .vpar_in(24'h010101),
    .x_res_in(11'h008), .y_res_in(11'h004), .pixel_in(18'h0F800), .pixel_take_out(), .frame_start_out());
  video_link_sva video_link_sva_inst (.clock_in(clock_in), .rst_in(rst_in), .pclk(link.pclk),
    .hsync(link.hsync), .vsync(link.vsync), .de(link.de), .data(link.data));
  // ==========================================
  // clock and tasks
  always #4 clock_in = ~clock_in;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clock_in);
    wr <= 1'h0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge clock_in);
    addr <= a;
    rd <= 1'h1;
    @(posedge clock_in);
    rd <= 1'h0;
    #1;
    chk(what, exp, rdata & m);
  endtask
  // bounded wait, sampled after the edge has settled
  task automatic wait_on(ref logic s, input logic v);
    for (int i = 0; i < 30000 && s !== v; i++) begin
      @(posedge clock_in);
      #1;
    end
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ==========================================
  // tests
  initial begin
    repeat (5) @(posedge clock_in);
    rst_in <= 1'h0;
    rd_chk("mode", 8'h00, 32'h100, 32'hFFFFFFFF);
    rd_chk("polarity", 8'h04, 32'h0, 32'hFFFFFFFF);
    wr_reg(8'h18, 32'hFF);
    rd_chk("status", 8'h18, 32'h0, 32'hFFFFFFFF);
    rd_chk("unmapped", 8'h40, 32'h0, 32'hFFFFFFFF);
    wr_reg(8'h08, 32'h123456);
    wr_reg(8'h0C, 32'h020202);
    wr_reg(8'h10, 32'h010101);
    wr_reg(8'h14, 32'h00040008);
    wr_reg(8'h00, 32'h205);
    src_en <= 1'h1;
    repeat (2000) @(posedge clock_in);
    chk("early lock", 32'h0, lock);
    chk("background", 32'h123456, pixel);
    wait_on(lock, 1'h1);
    chk("lock", 32'h1, lock);
    chk("use video", 32'h1, use_video);
    rd_chk("status locked", 8'h18, 32'h3F, 32'hFF);
    wait_on(pvalid, 1'h1);
    chk("pixel", 32'hFF0000, pixel);
    // one clock of pulse width off must break lock and the count
    wr_reg(8'h0C, 32'h020203);
    wait_on(lock, 1'h0);
    chk("lock lost", 32'h0, lock);
    wr_reg(8'h0C, 32'h020202);
    repeat (1500) @(posedge clock_in);
    chk("count restart", 32'h0, lock);
    wait_on(lock, 1'h1);
    chk("relock", 32'h1, lock);
    // hsync taken as active low makes the hsync width and the data enable positions wrong
    wr_reg(8'h04, 32'h1);
    wait_on(lock, 1'h0);
    chk("polarity lost", 32'h0, lock);
    wr_reg(8'h04, 32'h0);
    wait_on(lock, 1'h1);
    chk("polarity relock", 32'h1, lock);
    // stop in the front porch so no pulse on the pins is cut short
    wait_on(dde, 1'h1);
    repeat (120) @(posedge clock_in);
    src_en <= 1'h0;
    emb <= 1'h1;
    de_en <= 1'h0;
    src_hpar <= 24'h030302;
    wr_reg(8'h00, 32'h0);
    rd_chk("status off", 8'h18, 32'h0, 32'hFF);
    chk("lock off", 32'h0, lock);
    wr_reg(8'h0C, 32'h030302);
    wr_reg(8'h00, 32'h203);
    src_en <= 1'h1;
    wait_on(lock, 1'h1);
    chk("embedded lock", 32'h1, lock);
    // first pixel after lock is a zero data byte, no longer the background
    wait_on(pvalid, 1'h1);
    chk("embedded pixel", 32'h0, pixel);
    final_report();
  end
  // watchdog well beyond the roughly 19000 clocks the tests need
  initial begin
    repeat (60000) @(posedge clock_in);
    n_mismatch++;
    final_report();
  end
endmodule // parallel_video_input_lock_tb
